/* File: logic/rcw_consts.svh */
`ifndef RCW_CONSTS_SVH
`define RCW_CONSTS_SVH

// ------------------------------------------------------------------
// Register addresses
// ------------------------------------------------------------------
`define RCW_ADDR_CAUSE       8'h00
`define RCW_ADDR_PWR_CTRL    8'h01
`define RCW_ADDR_WAKE_CTRL   8'h02
`define RCW_ADDR_EXT_REF     8'h03
`define RCW_ADDR_EV_STATUS   8'h04
`define RCW_ADDR_EV_MASK     8'h05

// ------------------------------------------------------------------
// Reset-cause bit positions and the power-on value
// ------------------------------------------------------------------
`define RCW_CAUSE_POR        7
`define RCW_CAUSE_PIN        6
`define RCW_CAUSE_WDOG       5
`define RCW_CAUSE_BAD_OP     4
`define RCW_CAUSE_BAD_ADDR   3
`define RCW_CAUSE_LOWV       1
`define RCW_CAUSE_POR_VALUE  8'h82

// ------------------------------------------------------------------
// Control field positions
// ------------------------------------------------------------------
`define RCW_PWR_DET_EN       0
`define RCW_PWR_IRQ_EN       1
`define RCW_PWR_RST_EN       2
`define RCW_PWR_FLAG         3
`define RCW_PWR_ACK          4
`define RCW_WAKE_FLAG        7
`define RCW_WAKE_ACK         6
`define RCW_WAKE_CLK_SEL     5
`define RCW_WAKE_IRQ_EN      4
`define RCW_EXT_CLK_EN       0
`define RCW_EXT_STOP_EN      1
`define RCW_EV_LOWV          0
`define RCW_EV_WAKE          1

// ------------------------------------------------------------------
// Wakeup terminal counts (period minus one) in ticks of the selected 1 kHz-class source
// ------------------------------------------------------------------
`define RCW_PERIOD_1         10'd7
`define RCW_PERIOD_2         10'd31
`define RCW_PERIOD_3         10'd63
`define RCW_PERIOD_4         10'd127
`define RCW_PERIOD_5         10'd255
`define RCW_PERIOD_6         10'd511
`define RCW_PERIOD_7         10'd1023

`endif

/* File: logic/rcw_pkg.sv */
package rcw_pkg;

    // ------------------------------------------------------------------
    // Complete state of the control block, registered as one word.
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] cause;          // Reset-cause record.
        logic       lowv_detect_en; // Low-voltage detector enable.
        logic       lowv_irq_en;    // Low-voltage interrupt enable.
        logic       lowv_reset_en;  // Low-voltage reset enable.
        logic       lowv_flag;      // Low-voltage event flag.
        logic       periodic_flag;  // Periodic wakeup flag.
        logic       clk_sel;        // Periodic clock select.
        logic       pirq_en;        // Periodic interrupt enable.
        logic [2:0] rate;           // Periodic rate select.
        logic       ext_clk_en;     // External reference clock enable.
        logic       ext_stop_en;    // External reference stop enable.
        logic [1:0] ev_status;      // Sticky interrupt status.
        logic [1:0] ev_mask;        // Interrupt mask.
        logic [7:0] rdata;          // Read data, valid one cycle.
        logic       wd_restart;     // Watchdog restart pulse.
        logic       reset_req;      // Reset request pulse.
    } ctl_state_t;

endpackage

/* File: logic/rcw_timer_if.sv */
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Link between the control registers and the periodic timer.
// ------------------------------------------------------------------
interface rcw_timer_if;
    logic       clk_sel;   // Low picks the internal tick, high the external.
    logic [2:0] rate;      // Zero stops the timer.
    logic       tick_int;  // Internal 1 kHz tick, one cycle.
    logic       tick_ext;  // External reference tick, one cycle.
    logic       wake;      // One-cycle pulse at the end of a period.

    modport ctrl  (output clk_sel, output rate, output tick_int, output tick_ext,
                   input wake);
    modport timer (input clk_sel, input rate, input tick_int, input tick_ext,
                   output wake);
endinterface

/* File: logic/periodic_wake_timer.sv */
`timescale 1ns/1ps
`include "rcw_consts.svh"

module periodic_wake_timer
    import rcw_pkg::*;
#(
    parameter int COUNT_W = 10
) (
    // Clock and reset.
    input  wire logic   sys_clk,
    input  wire logic   reset_n,
    // Control side.
    rcw_timer_if.timer  tmr
);

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    if (COUNT_W < 10) begin : g_bad_width
        $error("periodic_wake_timer: COUNT_W must hold the longest period");
    end

    typedef struct packed {
        logic [COUNT_W-1:0] count;     // Ticks seen in this period.
        logic [2:0]         last_rate; // Rate of the previous cycle.
        logic               wake;      // Registered wake pulse.
    } tmr_state_t;

    tmr_state_t st_r;
    tmr_state_t st_nxt;
    logic       tick;                  // Tick of the selected source.
    logic [9:0] limit;                 // Terminal count for the rate.

    // The source choice decides which tick advances the count.
    always_comb begin
        tick = tmr.clk_sel ? tmr.tick_ext : tmr.tick_int;
        case (tmr.rate)
            3'h1:    limit = `RCW_PERIOD_1;
            3'h2:    limit = `RCW_PERIOD_2;
            3'h3:    limit = `RCW_PERIOD_3;
            3'h4:    limit = `RCW_PERIOD_4;
            3'h5:    limit = `RCW_PERIOD_5;
            3'h6:    limit = `RCW_PERIOD_6;
            3'h7:    limit = `RCW_PERIOD_7;
            default: limit = 10'h000;
        endcase
    end

    // Counting runs in every power mode: no mode input gates it.
    always_comb begin
        st_nxt           = st_r;
        st_nxt.wake      = 1'b0;
        st_nxt.last_rate = tmr.rate;
        if (tmr.rate == 3'h0 || tmr.rate != st_r.last_rate) begin
            // A rate of zero holds the timer idle; a new rate restarts it.
            st_nxt.count = '0;
        end else if (tick) begin
            if (st_r.count[9:0] == limit) begin
                st_nxt.count = '0;
                st_nxt.wake  = 1'b1;
            end else begin
                st_nxt.count = st_r.count + 1'b1;
            end
        end
    end

    // State register.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tmr.wake = st_r.wake;

endmodule

/* File: logic/reset_cause_and_periodic_wake.sv */
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`include "rcw_consts.svh"

module reset_cause_and_periodic_wake
    import rcw_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 8
) (
    // Clock and reset.
    input  wire logic              sys_clk,
    input  wire logic              reset_n,
    // Register port.
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    // Reset sources.
    input  wire logic              reset_pin_n,
    input  wire logic              watchdog_timeout,
    input  wire logic              watchdog_en,
    input  wire logic              bad_opcode_event,
    input  wire logic              stop_exec,
    input  wire logic              stop_allow,
    input  wire logic              background_halt_instr,
    input  wire logic              debug_mode_en,
    input  wire logic              bad_address_event,
    input  wire logic              debug_forced_reset,
    // Supply monitor.
    input  wire logic              low_supply,
    // Periodic timer ticks.
    input  wire logic              tick_1khz,
    input  wire logic              ext_ref_tick,
    // Outputs to the rest of the system.
    output logic                   sys_reset_req,
    output logic                   watchdog_restart,
    output logic                   lowv_irq_req,
    output logic                   periodic_irq_req,
    output logic                   ext_ref_clk_en,
    output logic                   ext_ref_stop_en,
    output logic                   irq
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    // The register map decodes eight address bits and eight data bits.
    if (ADDR_W != 8) begin : g_bad_addr
        $error("reset_cause_and_periodic_wake: ADDR_W must be 8");
    end
    if (DATA_W != 8) begin : g_bad_data
        $error("reset_cause_and_periodic_wake: DATA_W must be 8");
    end

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    ctl_state_t st_r;          // Registered state.
    ctl_state_t st_nxt;        // Next state.
    rcw_timer_if tmr_if ();    // Link to the periodic timer.

    logic       wr_cause;      // Write to the cause address.
    logic       wr_pwr;        // Write to the power control register.
    logic       wr_wake;       // Write to the periodic control register.
    logic       wr_ext;        // Write to the external reference register.
    logic       wr_mask;       // Write to the interrupt mask register.
    logic       rd_status;     // Read of the sticky status register.
    logic       lowv_trip;     // Supply low with the detector on.
    logic       lowv_rst;      // Low-voltage reset source.
    logic       lowv_irq_ev;   // Low-voltage interrupt event.
    logic       pin_rst;       // Reset pin source.
    logic       wdog_rst;      // Watchdog source.
    logic       bad_op_rst;    // Illegal opcode source.
    logic       reset_entry;   // Any reset source active this cycle.
    logic [1:0] ev_set;        // Events that set sticky status.
    logic [7:0] cause_new;     // Cause value captured at reset entry.
    logic [7:0] rd_value;      // Read data before registering.

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    // Strobes never coincide, so each decode is a plain match.
    always_comb begin
        wr_cause  = reg_wr && (reg_addr == `RCW_ADDR_CAUSE);
        wr_pwr    = reg_wr && (reg_addr == `RCW_ADDR_PWR_CTRL);
        wr_wake   = reg_wr && (reg_addr == `RCW_ADDR_WAKE_CTRL);
        wr_ext    = reg_wr && (reg_addr == `RCW_ADDR_EXT_REF);
        wr_mask   = reg_wr && (reg_addr == `RCW_ADDR_EV_MASK);
        rd_status = reg_rd && (reg_addr == `RCW_ADDR_EV_STATUS);
    end

    // ------------------------------------------------------------------
    // Reset sources
    // ------------------------------------------------------------------
    // The watchdog and low-voltage sources are qualified by their enables; the pin, bad-address and debug sources are not.
    always_comb begin
        lowv_trip   = low_supply && st_r.lowv_detect_en;
        // Reset mode and interrupt mode are mutually exclusive by the
        // reset enable, so one low supply never gives both.
        lowv_rst    = lowv_trip && st_r.lowv_reset_en;
        lowv_irq_ev = lowv_trip && st_r.lowv_irq_en && !st_r.lowv_reset_en;
        pin_rst     = !reset_pin_n;
        wdog_rst    = watchdog_timeout && watchdog_en;
        // A stop that is not allowed and a halt without debug mode are
        // illegal opcodes too.
        bad_op_rst  = bad_opcode_event
                      || (stop_exec && !stop_allow)
                      || (background_halt_instr && !debug_mode_en);
        reset_entry = pin_rst || wdog_rst || bad_op_rst || bad_address_event
                      || lowv_rst || debug_forced_reset;
    end

    // ------------------------------------------------------------------
    // Cause capture
    // ------------------------------------------------------------------
    // Every active source sets its bit and every inactive one clears
    // it. The power-on bit survives a low-voltage reset, as the supply
    // was already low; any other reset clears it.
    always_comb begin
        cause_new                       = 8'h00;
        cause_new[`RCW_CAUSE_POR]       = lowv_rst && st_r.cause[`RCW_CAUSE_POR];
        cause_new[`RCW_CAUSE_PIN]       = pin_rst;
        cause_new[`RCW_CAUSE_WDOG]      = wdog_rst;
        cause_new[`RCW_CAUSE_BAD_OP]    = bad_op_rst;
        cause_new[`RCW_CAUSE_BAD_ADDR]  = bad_address_event;
        cause_new[`RCW_CAUSE_LOWV]      = lowv_rst;
    end

    // ------------------------------------------------------------------
    // Interrupt events
    // ------------------------------------------------------------------
    // The periodic event only reaches the status register while its
    // local enable is set, so a masked timer cannot wake the core.
    always_comb begin
        ev_set               = 2'h0;
        ev_set[`RCW_EV_LOWV] = lowv_irq_ev;
        ev_set[`RCW_EV_WAKE] = tmr_if.wake && st_r.pirq_en;
    end

    // ------------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------------
    // Unmapped addresses and write-only bits read as zero.
    always_comb begin
        rd_value = 8'h00;
        case (reg_addr)
            `RCW_ADDR_CAUSE: begin
                rd_value = st_r.cause;
            end
            `RCW_ADDR_PWR_CTRL: begin
                rd_value[`RCW_PWR_DET_EN] = st_r.lowv_detect_en;
                rd_value[`RCW_PWR_IRQ_EN] = st_r.lowv_irq_en;
                rd_value[`RCW_PWR_RST_EN] = st_r.lowv_reset_en;
                rd_value[`RCW_PWR_FLAG]   = st_r.lowv_flag;
            end
            `RCW_ADDR_WAKE_CTRL: begin
                // The acknowledge bit position always reads zero.
                rd_value[`RCW_WAKE_FLAG]    = st_r.periodic_flag;
                rd_value[`RCW_WAKE_CLK_SEL] = st_r.clk_sel;
                rd_value[`RCW_WAKE_IRQ_EN]  = st_r.pirq_en;
                rd_value[2:0]               = st_r.rate;
            end
            `RCW_ADDR_EXT_REF: begin
                rd_value[`RCW_EXT_CLK_EN]  = st_r.ext_clk_en;
                rd_value[`RCW_EXT_STOP_EN] = st_r.ext_stop_en;
            end
            `RCW_ADDR_EV_STATUS: begin
                rd_value[1:0] = st_r.ev_status;
            end
            `RCW_ADDR_EV_MASK: begin
                rd_value[1:0] = st_r.ev_mask;
            end
            default: begin
                rd_value = 8'h00;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        st_nxt            = st_r;
        st_nxt.rdata      = reg_rd ? rd_value : 8'h00;
        st_nxt.wd_restart = wr_cause;
        st_nxt.reset_req  = reset_entry;

        // Cause record: no write path exists, only reset entry updates it.
        if (debug_forced_reset) begin
            st_nxt.cause = 8'h00;
        end else if (reset_entry) begin
            st_nxt.cause = cause_new;
        end

        // Power control register; the acknowledge bit clears the flag.
        if (wr_pwr) begin
            st_nxt.lowv_detect_en = reg_wdata[`RCW_PWR_DET_EN];
            st_nxt.lowv_irq_en    = reg_wdata[`RCW_PWR_IRQ_EN];
            st_nxt.lowv_reset_en  = reg_wdata[`RCW_PWR_RST_EN];
            if (reg_wdata[`RCW_PWR_ACK]) begin
                st_nxt.lowv_flag = 1'b0;
            end
        end
        // A new low-voltage event wins over an acknowledge.
        if (lowv_irq_ev) begin
            st_nxt.lowv_flag = 1'b1;
        end

        // Periodic control register.
        if (wr_wake) begin
            st_nxt.clk_sel = reg_wdata[`RCW_WAKE_CLK_SEL];
            st_nxt.pirq_en = reg_wdata[`RCW_WAKE_IRQ_EN];
            st_nxt.rate    = reg_wdata[2:0];
            if (reg_wdata[`RCW_WAKE_ACK]) begin
                st_nxt.periodic_flag = 1'b0;
            end
        end
        // The wake pulse wins over an acknowledge in the same cycle.
        if (tmr_if.wake) begin
            st_nxt.periodic_flag = 1'b1;
        end

        // External reference enables are plain software bits.
        if (wr_ext) begin
            st_nxt.ext_clk_en  = reg_wdata[`RCW_EXT_CLK_EN];
            st_nxt.ext_stop_en = reg_wdata[`RCW_EXT_STOP_EN];
        end

        // Interrupt mask.
        if (wr_mask) begin
            st_nxt.ev_mask = reg_wdata[1:0];
        end

        // Sticky status: a read clears it, a coincident event stays set.
        if (rd_status) begin
            st_nxt.ev_status = 2'h0;
        end
        st_nxt.ev_status = st_nxt.ev_status | ev_set;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // The asynchronous reset is the power-on reset of this always-on
    // block; internal resets are recorded, never applied here.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r       <= '0;
            st_r.cause <= `RCW_CAUSE_POR_VALUE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Periodic timer
    // ------------------------------------------------------------------
    // Ticks are passed straight through; the timer keeps counting
    // whatever the core's power mode, as no mode input reaches it.
    assign tmr_if.clk_sel  = st_r.clk_sel;
    assign tmr_if.rate     = st_r.rate;
    assign tmr_if.tick_int = tick_1khz;
    assign tmr_if.tick_ext = ext_ref_tick;

    periodic_wake_timer #(
        .COUNT_W (10)
    ) u_timer (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .tmr     (tmr_if.timer)
    );

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Bits two and zero of the cause record are never set by any path.
    assign reg_rdata        = st_r.rdata;
    assign sys_reset_req    = st_r.reset_req;
    assign watchdog_restart = st_r.wd_restart;
    assign lowv_irq_req     = st_r.lowv_flag && st_r.lowv_irq_en;
    assign periodic_irq_req = st_r.periodic_flag && st_r.pirq_en;
    assign ext_ref_clk_en   = st_r.ext_clk_en;
    assign ext_ref_stop_en  = st_r.ext_stop_en;
    // One level interrupt while any unmasked sticky bit is set.
    assign irq              = |(st_r.ev_status & st_r.ev_mask);

endmodule

/* File: bench/reset_cause_and_periodic_wake_chk.sv */
`timescale 1ns/1ps
module reset_cause_and_periodic_wake_chk
    import rcw_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 8
) (
    // Clock, reset and register port.
    input wire logic              sys_clk,
    input wire logic              reset_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    // Reset sources and supply monitor.
    input wire logic              reset_pin_n,
    input wire logic              watchdog_timeout,
    input wire logic              watchdog_en,
    input wire logic              bad_opcode_event,
    input wire logic              stop_exec,
    input wire logic              stop_allow,
    input wire logic              background_halt_instr,
    input wire logic              debug_mode_en,
    input wire logic              bad_address_event,
    input wire logic              debug_forced_reset,
    input wire logic              low_supply,
    // Outputs under watch.
    input wire logic              sys_reset_req,
    input wire logic              watchdog_restart,
    input wire logic              lowv_irq_req
);
    // All checks live in the one bus clock domain.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    // High when no reset source other than the watchdog could be active.
    wire quiet = reset_pin_n && !bad_opcode_event && !(stop_exec && !stop_allow)
        && !(background_halt_instr && !debug_mode_en) && !bad_address_event
        && !debug_forced_reset && !low_supply;

    // A debug reset, one quiet cycle, then a read of the cause register.
    sequence s_debug_then_read;
        debug_forced_reset ##1 (quiet && !watchdog_timeout)
            ##1 (quiet && reg_rd && reg_addr == 8'h00);
    endsequence

    chk_restart_on_write: assert property (
        reg_wr && reg_addr == 8'h00 |=> watchdog_restart)
        else $error("no watchdog restart after cause write");
    chk_restart_has_cause: assert property (
        watchdog_restart |-> $past(reg_wr) && $past(reg_addr) == 8'h00)
        else $error("watchdog restart without cause write");
    chk_pin_reset: assert property (!reset_pin_n |=> sys_reset_req)
        else $error("pin reset not requested");
    chk_wdog_gated: assert property (
        watchdog_timeout && !watchdog_en && quiet |=> !sys_reset_req)
        else $error("disabled watchdog caused reset");
    chk_stop_illegal: assert property (stop_exec && !stop_allow |=> sys_reset_req)
        else $error("disallowed stop did not reset");
    chk_bad_address: assert property (bad_address_event |=> sys_reset_req)
        else $error("bad address did not reset");
    chk_unused_zero: assert property (
        reg_rd && reg_addr == 8'h00 |=> reg_rdata[2] == 1'b0 && reg_rdata[0] == 1'b0)
        else $error("unused cause bits not zero");
    chk_debug_clear: assert property (s_debug_then_read |=> reg_rdata == 8'h00)
        else $error("debug reset left cause bits");
    chk_lowv_raise: assert property (
        $rose(lowv_irq_req) |-> $past(low_supply) || $past(reg_wr))
        else $error("low-voltage request without cause");
endmodule

bind reset_cause_and_periodic_wake reset_cause_and_periodic_wake_chk
    #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_chk (
    .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reset_pin_n(reset_pin_n),
    .watchdog_timeout(watchdog_timeout), .watchdog_en(watchdog_en),
    .bad_opcode_event(bad_opcode_event), .stop_exec(stop_exec), .stop_allow(stop_allow),
    .background_halt_instr(background_halt_instr), .debug_mode_en(debug_mode_en),
    .bad_address_event(bad_address_event), .debug_forced_reset(debug_forced_reset),
    .low_supply(low_supply), .sys_reset_req(sys_reset_req),
    .watchdog_restart(watchdog_restart), .lowv_irq_req(lowv_irq_req));

/* File: bench/test_reset_cause_and_periodic_wake.sv */
`timescale 1ns/1ps
module test_reset_cause_and_periodic_wake
    import rcw_pkg::*;
;
    // Bus and tick stimulus; src holds pin,wdog,badop,stop,halt,badaddr,debug.
    logic       sys_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic       low_supply = 1'b0, tick_1khz = 1'b0, ext_ref_tick = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, prev, exp_v;
    logic [6:0] src = 7'h00;
    logic [2:0] qual = 3'h7; // Watchdog enable, stop allowed, debug mode enabled.
    logic       sys_reset_req, watchdog_restart, lowv_irq_req, periodic_irq_req, irq;
    logic       ext_ref_clk_en, ext_ref_stop_en;
    int         mismatches = 0, comparisons = 0, seed = 98;

    always #4 sys_clk = ~sys_clk;

    reset_cause_and_periodic_wake i_dut (.sys_clk(sys_clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reset_pin_n(!src[6]), .watchdog_timeout(src[5]),
        .watchdog_en(qual[2]), .bad_opcode_event(src[4]), .stop_exec(src[3]),
        .stop_allow(qual[1]), .background_halt_instr(src[2]), .debug_mode_en(qual[0]),
        .bad_address_event(src[1]), .debug_forced_reset(src[0]), .low_supply(low_supply),
        .tick_1khz(tick_1khz), .ext_ref_tick(ext_ref_tick), .sys_reset_req(sys_reset_req),
        .watchdog_restart(watchdog_restart), .lowv_irq_req(lowv_irq_req),
        .periodic_irq_req(periodic_irq_req), .ext_ref_clk_en(ext_ref_clk_en),
        .ext_ref_stop_en(ext_ref_stop_en), .irq(irq));

    // Cause expected after one cycle of the given sources; nothing active keeps the old value.
    function automatic logic [7:0] exp_cause(input logic [6:0] s, input logic [2:0] q,
                                             input logic [7:0] old);
        logic [7:0] c;
        c = {1'b0, s[6], s[5] & q[2], s[4] | (s[3] & !q[1]) | (s[2] & !q[0]), s[1], 3'b000};
        if (s[0]) return 8'h00;
        return (c != 8'h00) ? c : old;
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        comparisons++;
        if (seen !== want) begin
            mismatches++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk); reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge sys_clk); reg_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe, so look at its falling edge.
    task automatic rd(input logic [7:0] a, input logic [7:0] want);
        @(posedge sys_clk); reg_addr <= a; reg_rd <= 1'b1;
        @(posedge sys_clk); reg_rd <= 1'b0;
        @(negedge sys_clk); check(reg_rdata, want);
    endtask

    task automatic ticks(input int n, input logic ext);
        repeat (n) begin
            @(posedge sys_clk); tick_1khz <= !ext; ext_ref_tick <= ext;
            @(posedge sys_clk); tick_1khz <= 1'b0; ext_ref_tick <= 1'b0;
        end
        repeat (3) @(posedge sys_clk);
    endtask

    task automatic give_verdict();
        if (mismatches == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Hang guard: the whole sequence needs only a few hundred cycles.
    initial begin
        #400000;
        mismatches++;
        give_verdict();
    end

    initial begin
        logic [6:0] s;
        logic [2:0] q;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        rd(8'h00, 8'h82);
        rd(8'h3c, 8'h00);
        wr(8'h05, 8'h03);
        wr(8'h02, 8'h11);
        ticks(8, 1'b0);
        rd(8'h02, 8'h91);
        check({7'h00, periodic_irq_req}, 8'h01);
        rd(8'h04, 8'h02);
        check({7'h00, irq}, 8'h00);
        wr(8'h02, 8'h41);
        rd(8'h02, 8'h01);
        ticks(8, 1'b0);
        rd(8'h02, 8'h81);
        check({7'h00, periodic_irq_req}, 8'h00);
        wr(8'h02, 8'h61);
        ticks(8, 1'b0);
        rd(8'h02, 8'h21);
        // Software turns the external reference on before relying on it.
        wr(8'h03, 8'h03);
        rd(8'h03, 8'h03);
        check({6'h00, ext_ref_stop_en, ext_ref_clk_en}, 8'h03);
        ticks(8, 1'b1);
        rd(8'h02, 8'ha1);
        wr(8'h02, 8'h40);
        ticks(16, 1'b0);
        rd(8'h02, 8'h00);
        // Low supply in interrupt mode, then in reset mode.
        wr(8'h01, 8'h03);
        @(posedge sys_clk); low_supply <= 1'b1;
        @(posedge sys_clk); low_supply <= 1'b0;
        rd(8'h01, 8'h0b);
        check({7'h00, lowv_irq_req}, 8'h01);
        wr(8'h01, 8'h05);
        @(posedge sys_clk); low_supply <= 1'b1;
        @(posedge sys_clk); low_supply <= 1'b0;
        // A low-voltage reset leaves the power-on bit as it was.
        rd(8'h00, 8'h82);
        wr(8'h01, 8'h10);
        prev = 8'h82;
        // Gated watchdog and legal stop first, then random source mixes.
        for (int i = 0; i < 30; i++) begin
            s = (i == 0) ? 7'h20 : (i == 1) ? 7'h0c : 7'($random(seed) & $random(seed));
            q = (i < 2) ? 3'h3 : 3'($random(seed));
            exp_v = exp_cause(s, q, prev);
            @(posedge sys_clk); src <= s; qual <= q;
            @(posedge sys_clk); src <= 7'h00;
            rd(8'h00, exp_v);
            prev = exp_v;
        end
        wr(8'h00, 8'($random(seed)));
        rd(8'h00, prev);
        give_verdict();
    end
endmodule
